// file: rtl/sscc_params.svh
// Constants for the spread spectrum clock control block
`ifndef SSCC_PARAMS_SVH
`define SSCC_PARAMS_SVH

// ----------------------------------------------------------------
// Command codes and control byte indices
// ----------------------------------------------------------------
`define SSCC_CMD_BYTE_PFX   6'h20
`define SSCC_CMD_BLOCK      8'h00
`define SSCC_IDX_SPREAD     2'h0
`define SSCC_IDX_CTRL       2'h1
`define SSCC_IDX_STATUS     2'h2
`define SSCC_IDX_CPUMP      2'h3
`define SSCC_BLOCK_LEN      8'h04

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SSCC_B0_SW_MODE     4
`define SSCC_B0_SS_EN       5
`define SSCC_B1_OUT_EN      2
`define SSCC_B0_RST         8'h20
`define SSCC_B1_RST         8'h04

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSCC_CLK_MHZ        100
`define SSCC_VCO_SETTLE_US  100
`define SSCC_VCO_SETTLE_CYC (`SSCC_VCO_SETTLE_US * `SSCC_CLK_MHZ)
`define SSCC_STEP_DWELL_NS  1000
`define SSCC_STEP_DWELL_CYC \
	((`SSCC_STEP_DWELL_NS * `SSCC_CLK_MHZ + 999) / 1000)
`define SSCC_STOP_GUARD     8

`endif

// file: rtl/sscc_pkg.sv
// Types shared by the spread spectrum clock control block
package sscc_pkg;

	// Shutdown sequencing states
	typedef enum logic [2:0]
	{
		SSCC_ST_RUN    = 3'b001,
		SSCC_ST_STOP   = 3'b010,
		SSCC_ST_SETTLE = 3'b100
	} sscc_state_t;

	// Host transfer phases
	typedef enum logic [3:0]
	{
		SSCC_PH_IDLE  = 4'b0001,
		SSCC_PH_CODE  = 4'b0010,
		SSCC_PH_COUNT = 4'b0100,
		SSCC_PH_DATA  = 4'b1000
	} sscc_phase_t;

endpackage

// file: rtl/sscc_top.sv
// Spread spectrum clock control: config, shutdown, output gating
`timescale 1ns/1ps
`include "sscc_params.svh"

// Operation
// - At reset spread is enabled and pin (hardware) control is selected.
// - Hardware mode takes select bits 3..1 from pins, bit 0 zero.
// - Software mode lets host write all four select bits.
// - Pump 00: bit3 low down 0.65-2.25, high center 0.25-1.10.
// - Select changes move modulation smoothly, one code per dwell.
// - Pump field in control byte resets 00, host writable.
// - Pump 11 gives slightly larger spread for the same codes.
// - Pump 01 gives the largest spread amounts.
// - Shutdown input is asynchronous active high, synchronised inside.
// - During shutdown outputs tri-state, oscillator and PLL power down.
// - Clocks stop synchronously, no glitch or runt pulse.
// - After shutdown release outputs stay stopped until VCO settles.
// - Control byte bit 2 gates output; PLL keeps running.
// - Disabled output tri-states glitch free, restarts cleanly.
// - Byte access code 100000xx selects control byte by low bits.
// - All-zero code selects block access with leading byte count.
module sscc_top
#(
	parameter int SETTLE_CYC = `SSCC_VCO_SETTLE_CYC, // VCO settle
	parameter int DWELL_CYC  = `SSCC_STEP_DWELL_CYC  // Per step
)
(
	input  wire logic       i_clock,               // Core clock
	input  wire logic       i_srst,                // Sync reset
	input  wire logic       i_reference_clock,     // Link clock
	input  wire logic       i_shutdown_request,    // Async pin
	input  wire logic [2:0] i_spread_config,       // Pins S3..S1
	input  wire logic       i_xfer_start,          // New transfer
	input  wire logic       i_wr_valid,            // Host byte
	input  wire logic [7:0] i_wr_byte,             // Host data
	input  wire logic       i_rd_req,              // Read request
	output logic            o_rd_valid,            // Read pulse
	output logic      [7:0] o_rd_byte,             // Read data
	output logic            o_spread_enable,       // To synth
	output logic      [3:0] o_spread_select,       // To synth
	output logic      [1:0] o_charge_pump,         // To synth
	output logic            o_synth_power_down,    // Osc and PLL
	output logic            o_diff_clock_output,   // True
	output logic            o_diff_clock_output_n, // Complement
	output logic            o_diff_clock_oe        // Drive enable
);
	import sscc_pkg::*;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	localparam int CW = $clog2(SETTLE_CYC + `SSCC_STOP_GUARD + 1);
	localparam int DW = $clog2(DWELL_CYC + 1);

	typedef struct packed
	{
		sscc_state_t st;
		logic [1:0]  sd_s;
		logic [1:0]  ack_s;
		logic [2:0]  cfg_s1;
		logic [2:0]  cfg_s2;
		logic [7:0]  b0;
		logic [7:0]  b1;
		sscc_phase_t ph;
		logic [1:0]  idx;
		logic        blk;
		logic [7:0]  cnt;
		logic        rd_valid;
		logic [7:0]  rd_byte;
		logic [3:0]  ss;
		logic [1:0]  cp;
		logic [DW-1:0] dwell;
		logic [CW-1:0] settle;
		logic        run_req;
		logic        pwr_dn;
	} sscc_core_t;

	typedef struct packed
	{
		logic [1:0] rst_s;
		logic [1:0] run_s;
		logic       clk;
		logic       clk_n;
		logic       oe;
		logic       stopped;
	} sscc_link_t;

	localparam sscc_core_t CORE_RST = '{
		st:      SSCC_ST_RUN,
		ph:      SSCC_PH_IDLE,
		b0:      `SSCC_B0_RST,
		b1:      `SSCC_B1_RST,
		default: '0
	};

	sscc_core_t cs;
	sscc_core_t next_cs;
	sscc_link_t ls;
	sscc_link_t next_ls;
	logic [3:0] tgt;
	logic [7:0] rd_sel;

	// ----------------------------------------------------------------
	// Spread target and read mux
	// ----------------------------------------------------------------
	// Pin mode keeps the lowest select bit at zero
	assign tgt = cs.b0[`SSCC_B0_SW_MODE] ? cs.b0[3:0]
		: {cs.cfg_s2, 1'b0};

	// Byte 2 reports live state, byte 3 the applied pump
	always_comb
	begin
		if (cs.idx == `SSCC_IDX_SPREAD)
			rd_sel = cs.b0;
		else if (cs.idx == `SSCC_IDX_CTRL)
			rd_sel = cs.b1;
		else if (cs.idx == `SSCC_IDX_STATUS)
			rd_sel = {1'b0, cs.pwr_dn, cs.sd_s[1], !cs.ack_s[1], cs.ss};
		else
			rd_sel = {6'h00, cs.cp};
	end

	// ----------------------------------------------------------------
	// Core next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cs = cs;
		next_cs.sd_s = {cs.sd_s[0], i_shutdown_request};
		next_cs.ack_s = {cs.ack_s[0], ls.stopped};
		next_cs.cfg_s1 = i_spread_config;
		next_cs.cfg_s2 = cs.cfg_s1;
		next_cs.rd_valid = 1'b0;

		// Host transfer decode; a new start aborts any transfer
		if (i_xfer_start)
			next_cs.ph = SSCC_PH_CODE;
		else if (i_wr_valid)
		begin
			if (cs.ph == SSCC_PH_CODE)
			begin
				if (i_wr_byte[7:2] == `SSCC_CMD_BYTE_PFX)
				begin
					next_cs.idx = i_wr_byte[1:0];
					next_cs.blk = 1'b0;
					next_cs.ph = SSCC_PH_DATA;
				end
				else if (i_wr_byte == `SSCC_CMD_BLOCK)
				begin
					next_cs.idx = `SSCC_IDX_SPREAD;
					next_cs.blk = 1'b1;
					next_cs.ph = SSCC_PH_COUNT;
				end
				else
					next_cs.ph = SSCC_PH_IDLE;
			end
			else if (cs.ph == SSCC_PH_COUNT)
			begin
				next_cs.cnt = i_wr_byte;
				next_cs.ph = SSCC_PH_DATA;
			end
			else if (cs.ph == SSCC_PH_DATA
				&& (!cs.blk || cs.cnt != 8'h00))
			begin
				// Status and pump readback bytes ignore writes
				if (cs.idx == `SSCC_IDX_SPREAD)
					next_cs.b0 = {2'b00, i_wr_byte[5:0]};
				else if (cs.idx == `SSCC_IDX_CTRL)
					next_cs.b1 = {5'h00, i_wr_byte[2:0]};
				next_cs.idx = cs.idx + 2'h1;
				next_cs.cnt = cs.cnt - 8'h01;
				if (!cs.blk)
					next_cs.ph = SSCC_PH_IDLE;
			end
		end
		else if (i_rd_req)
		begin
			next_cs.rd_valid = 1'b1;
			if (cs.ph == SSCC_PH_COUNT)
			begin
				// Block read opens with the byte count
				next_cs.rd_byte = `SSCC_BLOCK_LEN;
				next_cs.cnt = `SSCC_BLOCK_LEN;
				next_cs.ph = SSCC_PH_DATA;
			end
			else if (cs.ph == SSCC_PH_DATA)
			begin
				next_cs.rd_byte = rd_sel;
				next_cs.idx = cs.idx + 2'h1;
				if (!cs.blk)
					next_cs.ph = SSCC_PH_IDLE;
			end
			else
				next_cs.rd_byte = 8'h00;
		end

		// Modulation ramp: one code per dwell, pump swapped at code 0
		// so the synthesizer never jumps between spread amounts
		if (cs.dwell != '0)
			next_cs.dwell = cs.dwell - DW'(1);
		else if (cs.cp != cs.b1[1:0])
		begin
			if (cs.ss != 4'h0)
				next_cs.ss = cs.ss - 4'h1;
			else
				next_cs.cp = cs.b1[1:0];
			next_cs.dwell = DW'(DWELL_CYC);
		end
		else if (cs.ss < tgt)
		begin
			next_cs.ss = cs.ss + 4'h1;
			next_cs.dwell = DW'(DWELL_CYC);
		end
		else if (cs.ss > tgt)
		begin
			next_cs.ss = cs.ss - 4'h1;
			next_cs.dwell = DW'(DWELL_CYC);
		end

		// Shutdown sequencing
		case (cs.st)
			SSCC_ST_RUN:
			begin
				next_cs.run_req = cs.b1[`SSCC_B1_OUT_EN];
				if (cs.sd_s[1])
				begin
					next_cs.st = SSCC_ST_STOP;
					next_cs.run_req = 1'b0;
					next_cs.settle = CW'(`SSCC_STOP_GUARD);
				end
			end
			SSCC_ST_STOP:
			begin
				// Guard lets a stale stopped flag clear first
				next_cs.run_req = 1'b0;
				if (cs.settle != '0)
					next_cs.settle = cs.settle - CW'(1);
				else if (!cs.pwr_dn)
				begin
					if (cs.ack_s[1])
						next_cs.pwr_dn = 1'b1;
				end
				else if (!cs.sd_s[1])
				begin
					next_cs.pwr_dn = 1'b0;
					next_cs.st = SSCC_ST_SETTLE;
					next_cs.settle = CW'(SETTLE_CYC);
				end
			end
			SSCC_ST_SETTLE:
			begin
				next_cs.run_req = 1'b0;
				if (cs.sd_s[1])
				begin
					next_cs.st = SSCC_ST_STOP;
					next_cs.settle = CW'(`SSCC_STOP_GUARD);
				end
				else if (cs.settle != '0)
					next_cs.settle = cs.settle - CW'(1);
				else
					next_cs.st = SSCC_ST_RUN;
			end
			default:
				next_cs.st = SSCC_ST_RUN;
		endcase
	end

	// Core register
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			cs <= CORE_RST;
		else
			cs <= next_cs;
	end

	// ----------------------------------------------------------------
	// Link side output gating
	// ----------------------------------------------------------------
	// Stop only after a low phase, start from low: no runt pulses
	always_comb
	begin
		next_ls = ls;
		next_ls.rst_s = {ls.rst_s[0], i_srst};
		next_ls.run_s = {ls.run_s[0], cs.run_req};
		if (ls.rst_s[1])
		begin
			next_ls.clk = 1'b0;
			next_ls.clk_n = 1'b1;
			next_ls.oe = 1'b0;
			next_ls.stopped = 1'b1;
		end
		else if (ls.run_s[1])
		begin
			if (!ls.oe)
			begin
				next_ls.oe = 1'b1;
				next_ls.stopped = 1'b0;
			end
			else
			begin
				next_ls.clk = !ls.clk;
				next_ls.clk_n = ls.clk;
			end
		end
		else if (ls.clk)
		begin
			next_ls.clk = 1'b0;
			next_ls.clk_n = 1'b1;
		end
		else
		begin
			next_ls.oe = 1'b0;
			next_ls.stopped = 1'b1;
		end
	end

	// Link register; the reference clock must keep running
	always_ff @(posedge i_reference_clock)
	begin
		ls <= next_ls;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_rd_valid = cs.rd_valid;
	assign o_rd_byte = cs.rd_byte;
	assign o_spread_enable = cs.b0[`SSCC_B0_SS_EN];
	assign o_spread_select = cs.ss;
	assign o_charge_pump = cs.cp;
	assign o_synth_power_down = cs.pwr_dn;
	assign o_diff_clock_output = ls.clk;
	assign o_diff_clock_output_n = ls.clk_n;
	assign o_diff_clock_oe = ls.oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_srst);

	// Data byte of a byte-mode access to the control byte; the host
	// may leave idle cycles between the code and the data byte
	sequence s_ctrl_write;
		!i_xfer_start && i_wr_valid && cs.ph == SSCC_PH_DATA
			&& !cs.blk && cs.idx == `SSCC_IDX_CTRL;
	endsequence

	sequence s_wake;
		$fell(o_synth_power_down);
	endsequence

	AST_RESET_DEFAULTS:
	assert property ($past(i_srst) |-> o_spread_enable
		&& !cs.b0[`SSCC_B0_SW_MODE] && o_charge_pump == 2'h0)
	else $error("reset defaults wrong");

	AST_HW_LSB_ZERO:
	assert property (!cs.b0[`SSCC_B0_SW_MODE] && cs.dwell == '0
		&& cs.cp == cs.b1[1:0] && o_spread_select == tgt
		|-> !o_spread_select[0])
	else $error("pin mode select bit 0 not zero");

	AST_STEP_ONE:
	assert property ($changed(o_spread_select) |->
		$past(cs.dwell) == '0
		&& (o_spread_select == $past(o_spread_select) + 4'h1
		|| o_spread_select + 4'h1 == $past(o_spread_select)))
	else $error("spread select jumped");

	AST_CP_AT_ZERO:
	assert property ($changed(o_charge_pump) |->
		o_spread_select == 4'h0 && $past(cs.dwell) == '0)
	else $error("pump changed off code zero");

	AST_CTRL_WRITE:
	assert property (s_ctrl_write |=>
		cs.b1[2:0] == $past(i_wr_byte[2:0]))
	else $error("control byte write lost");

	AST_BYTE_READ:
	assert property (i_rd_req && !i_xfer_start && !i_wr_valid
		&& cs.ph == SSCC_PH_DATA && !cs.blk
		&& cs.idx == `SSCC_IDX_CTRL
		|=> o_rd_valid && o_rd_byte == $past(cs.b1))
	else $error("byte read data wrong");

	AST_SD_STOPS:
	assert property (cs.sd_s[1] && cs.st == SSCC_ST_RUN
		|=> !cs.run_req && cs.st == SSCC_ST_STOP)
	else $error("shutdown not taken");

	AST_PD_AFTER_STOP:
	assert property ($rose(o_synth_power_down) |->
		cs.st == SSCC_ST_STOP && $past(cs.ack_s[1]) && !cs.run_req)
	else $error("power down before clock stop");

	AST_SETTLE_HOLD:
	assert property (s_wake |-> !cs.run_req [*8])
	else $error("output restarted before settle");

	AST_OFF_AT_LOW:
	assert property (@(posedge i_reference_clock)
		disable iff (ls.rst_s[1])
		$fell(ls.oe) |-> !ls.clk && $past(ls.clk) == 1'b0)
	else $error("output released while high");

	AST_TRISTATE:
	assert property (@(posedge i_reference_clock)
		disable iff (ls.rst_s[1])
		!ls.run_s[1] && !ls.clk |=> !ls.oe && ls.stopped)
	else $error("output not tri-stated");

endmodule

// file: verification/sscc_ref_source.sv
// Reference clock source standing at the link side of the block
`timescale 1ns/1ps

module sscc_ref_source
#(
	parameter real HALF_NS  = 15.0, // Half period, 30 ns clock
	parameter real PHASE_NS = 2.0   // Start offset to core clock
)
(
	output logic o_reference_clock  // Free-running reference
);

	// ----------------------------------------------------------------
	// Clock generation
	// ----------------------------------------------------------------
	// Runs through shutdown and reset: the output stop sequence
	// depends on link edges to finish its high phase cleanly
	initial
	begin
		o_reference_clock = 1'b0;
		#(PHASE_NS);
		forever #(HALF_NS) o_reference_clock = ~o_reference_clock;
	end

endmodule

// file: verification/testbench.sv
// Self-checking bench for the spread spectrum clock control block
`timescale 1ns/1ps

module testbench;
	import sscc_pkg::*;

	localparam int SETTLE = 20; // Short VCO settle for simulation
	localparam int DWELL  = 2;  // Short ramp dwell for simulation

	logic       i_clock;
	logic       i_srst;
	logic       i_reference_clock;
	logic       i_shutdown_request;
	logic [2:0] i_spread_config;
	logic       i_xfer_start;
	logic       i_wr_valid;
	logic [7:0] i_wr_byte;
	logic       i_rd_req;
	logic       o_rd_valid;
	logic [7:0] o_rd_byte;
	logic       o_spread_enable;
	logic [3:0] o_spread_select;
	logic [1:0] o_charge_pump;
	logic       o_synth_power_down;
	logic       o_diff_clock_output;
	logic       o_diff_clock_output_n;
	logic       o_diff_clock_oe;
	logic [3:0] prev_sel;
	logic [1:0] prev_pump;
	int         bad_count;
	int         compares;
	int         n;

	sscc_ref_source u_ref (.o_reference_clock(i_reference_clock));

	sscc_top #(.SETTLE_CYC(SETTLE), .DWELL_CYC(DWELL)) u_dut
	(
		.i_clock               (i_clock),
		.i_srst                (i_srst),
		.i_reference_clock     (i_reference_clock),
		.i_shutdown_request    (i_shutdown_request),
		.i_spread_config       (i_spread_config),
		.i_xfer_start          (i_xfer_start),
		.i_wr_valid            (i_wr_valid),
		.i_wr_byte             (i_wr_byte),
		.i_rd_req              (i_rd_req),
		.o_rd_valid            (o_rd_valid),
		.o_rd_byte             (o_rd_byte),
		.o_spread_enable       (o_spread_enable),
		.o_spread_select       (o_spread_select),
		.o_charge_pump         (o_charge_pump),
		.o_synth_power_down    (o_synth_power_down),
		.o_diff_clock_output   (o_diff_clock_output),
		.o_diff_clock_output_n (o_diff_clock_output_n),
		.o_diff_clock_oe       (o_diff_clock_oe)
	);

	// ----------------------------------------------------------------
	// Clock, verdict and comparison
	// ----------------------------------------------------------------
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	task give_verdict;
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// ----------------------------------------------------------------
	// Monitors
	// ----------------------------------------------------------------
	// Applied code moves one step at a time; pump swaps only at zero
	always @(posedge i_clock)
	begin
		if (!i_srst && o_spread_select !== prev_sel)
			check("select step", {7'h0,
				o_spread_select == prev_sel + 4'h1
				|| o_spread_select + 4'h1 == prev_sel}, 8'h01);
		if (!i_srst && o_charge_pump !== prev_pump)
			check("pump swap at zero", {4'h0, o_spread_select}, 8'h00);
		prev_sel  <= o_spread_select;
		prev_pump <= o_charge_pump;
	end

	// A driven differential pair is always complementary
	always @(posedge i_reference_clock)
		if (o_diff_clock_oe === 1'b1 && o_diff_clock_output === o_diff_clock_output_n)
			check("pair complement", 8'h00, 8'h01);

	// ----------------------------------------------------------------
	// Host access tasks: every strobe lasts one clock
	// ----------------------------------------------------------------
	task wr(input logic [7:0] b);
		@(posedge i_clock);
		#1 i_wr_valid = 1'b1;
		i_wr_byte = b;
		@(posedge i_clock);
		#1 i_wr_valid = 1'b0;
	endtask

	task xfer(input logic [7:0] code);
		@(posedge i_clock);
		#1 i_xfer_start = 1'b1;
		@(posedge i_clock);
		#1 i_xfer_start = 1'b0;
		wr(code);
	endtask

	task automatic rd(input string name, input logic [7:0] exp);
		int k;
		@(posedge i_clock);
		#1 i_rd_req = 1'b1;
		@(posedge i_clock);
		#1 i_rd_req = 1'b0;
		for (k = 0; k < 3 && o_rd_valid !== 1'b1; k++)
		begin
			@(posedge i_clock);
			#1;
		end
		check({name, " valid"}, {7'h0, o_rd_valid}, 8'h01);
		check(name, o_rd_byte, exp);
	endtask

	task reg_write(input logic [1:0] idx, input logic [7:0] data);
		xfer({6'h20, idx});
		wr(data);
	endtask

	task reg_read(input string name, input logic [1:0] idx, input logic [7:0] exp);
		xfer({6'h20, idx});
		rd(name, exp);
	endtask

	// Bounded waits; a bound that runs out ends the run
	task automatic wait_cfg(input logic [5:0] v);
		int k;
		for (k = 0; k < 1000 && {o_charge_pump, o_spread_select} !== v; k++)
		begin
			@(posedge i_clock);
			#1;
		end
		check("pump and select", {2'h0, o_charge_pump, o_spread_select}, {2'h0, v});
		if (k == 1000)
			give_verdict();
	endtask

	task automatic wait_bit(input bit use_oe, input logic v, output int k);
		for (k = 0; k < 2000; k++)
		begin
			if ((use_oe ? o_diff_clock_oe : o_synth_power_down) === v)
				break;
			@(posedge i_clock);
			#1;
		end
		if (k == 2000)
		begin
			check("wait bound", 8'h00, 8'h01);
			give_verdict();
		end
	endtask

	task do_reset;
		#1 i_srst = 1'b1;
		repeat (6) @(posedge i_clock);
		#1 i_srst = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		bad_count = 0;
		compares = 0;
		i_srst = 1'b1;
		i_shutdown_request = 1'b0;
		i_spread_config = 3'h0;
		i_xfer_start = 1'b0;
		i_wr_valid = 1'b0;
		i_wr_byte = 8'h00;
		i_rd_req = 1'b0;
		do_reset();
		check("spread enable", {7'h0, o_spread_enable}, 8'h01);
		reg_read("byte0 reset", 2'h0, 8'h20);
		reg_read("spread_output_control reset", 2'h1, 8'h04);
		wait_bit(1'b1, 1'b1, n);
		// Pin mode: pins feed bits 3..1, bit 0 stays low
		i_spread_config = 3'h5;
		wait_cfg(6'h0a);
		// Software mode takes all four bits from the host
		reg_write(2'h0, 8'h3f);
		wait_cfg(6'h0f);
		reg_write(2'h1, 8'h07);
		wait_cfg(6'h3f);
		reg_read("applied pump", 2'h3, 8'h03);
		reg_write(2'h1, 8'h05);
		wait_cfg(6'h1f);
		reg_write(2'h1, 8'h04);
		reg_write(2'h0, 8'h37);
		wait_cfg(6'h07);
		// Block read: count first, then bytes from index 0
		xfer(8'h00);
		rd("block count", 8'h04);
		rd("block byte0", 8'h37);
		rd("block spread_output_control", 8'h04);
		// Block write of two bytes
		xfer(8'h00);
		wr(8'h02);
		wr(8'h32);
		wr(8'h07);
		wait_cfg(6'h32);
		// Bad code and read-only byte leave state alone
		xfer(8'h55);
		wr(8'h00);
		reg_read("after bad code", 2'h1, 8'h07);
		reg_write(2'h3, 8'h00);
		reg_read("ro byte3", 2'h3, 8'h03);
		// Output disable keeps the synthesizer powered
		reg_write(2'h1, 8'h03);
		wait_bit(1'b1, 1'b0, n);
		check("pll on while off", {7'h0, o_synth_power_down}, 8'h00);
		reg_write(2'h1, 8'h07);
		wait_bit(1'b1, 1'b1, n);
		// Shutdown and restart after settling
		i_shutdown_request = 1'b1;
		wait_bit(1'b0, 1'b1, n);
		check("oe in shutdown", {7'h0, o_diff_clock_oe}, 8'h00);
		@(posedge i_clock);
		#1 i_shutdown_request = 1'b0;
		wait_bit(1'b0, 1'b0, n);
		wait_bit(1'b1, 1'b1, n);
		check("settle held", {7'h0, n >= SETTLE}, 8'h01);
		// Second reset in mid-run restores defaults
		i_spread_config = 3'h0;
		do_reset();
		reg_read("byte0 rereset", 2'h0, 8'h20);
		reg_read("spread_output_control rereset", 2'h1, 8'h04);
		give_verdict();
	end

endmodule
